// [verilog/tbx_pkg.sv]
// Package for the bus exchanger controller: register map, fields, types
package tbx_pkg;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WDATA  = 8'h08;
	localparam logic [7:0] ADDR_RDATA  = 8'h0c;
	localparam logic [7:0] ADDR_CMD    = 8'h10;
	localparam logic [7:0] ADDR_TIMING = 8'h14;
	localparam int unsigned CTRL_UPPER = 0;
	localparam int unsigned CTRL_LOWER = 1;
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_EVEN   = 2;
	localparam logic [1:0] CMD_WRITE   = 2'h1;
	localparam logic [1:0] CMD_SINGLE  = 2'h2;
	localparam logic [1:0] CMD_PAIR    = 2'h3;
	localparam int unsigned STAT_BUSY  = 0;
	localparam int unsigned STAT_FULL  = 1;
	localparam int unsigned STAT_EMPTY = 2;
	localparam int unsigned STAT_WFULL = 3;
	localparam logic [1:0] CTRL_RESET  = 2'h3;
	localparam logic [3:0] TIMING_RESET = 4'h2;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

	typedef struct packed {
		logic [15:0] data;
		logic        oe;
		logic [15:0] in;
	} tbx_bus_t;

	typedef struct packed {
		logic port_sel;
		logic dir_sel;
		logic upper_byte_drive_n;
		logic lower_byte_drive_n;
		logic even_read_latch_en;
		logic odd_read_latch_en;
		logic even_write_latch_en;
		logic odd_write_latch_en;
	} tbx_ctl_t;
endpackage : tbx_pkg

// [verilog/tbx_fifo.sv]
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module tbx_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clock_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop  = out_valid_o && out_ready_i;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : tbx_fifo

// [verilog/tbx_ctrl.sv]
// Controller that steers a three-port bus exchanger for CPU reads/writes
`timescale 1ns/100ps
module tbx_ctrl (
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             port_sel_o,
	output logic             dir_sel_o,
	output logic             upper_byte_drive_n_o,
	output logic             lower_byte_drive_n_o,
	output logic             even_read_latch_en_o,
	output logic             odd_read_latch_en_o,
	output logic             even_write_latch_en_o,
	output logic             odd_write_latch_en_o,
	input  wire logic [15:0] cpu_data_i,
	output logic [15:0]      cpu_data_o,
	output logic             cpu_data_oe_o
);
	// Pair reads walk open, capture, even word, odd word
	typedef enum logic [2:0] {
		ST_IDLE, ST_WRITE, ST_OPEN, ST_CAPTURE, ST_EVEN, ST_ODD
	} tbx_state_t;

	tbx_state_t         state;
	tbx_pkg::tbx_ctl_t  ctl;
	logic [1:0]         byte_ctrl;
	logic [3:0]         wait_cycles;
	logic [3:0]         wait_cnt;
	logic [15:0]        wdata;
	logic               wdata_full;
	logic [1:0]         cmd_op;
	logic               cmd_even;
	logic               cmd_go;
	logic [15:0]        cpu_s1;
	logic [15:0]        cpu_s2;
	logic [15:0]        fifo_in;
	logic               fifo_push;
	logic               fifo_ready;
	logic [15:0]        fifo_out;
	logic               fifo_valid;
	logic               fifo_pop;
	logic               acc;
	logic               wr_acc;
	logic               rd_acc;
	logic               busy;
	logic               wait_done;
	logic               take;
	logic [2:0]         take_pipe;
	logic               room;

	// Strobe decode for one register word
	function automatic logic reg_hit(input logic strobe,
		input logic [7:0] addr, input logic [7:0] target);
		return strobe && (addr == target);
	endfunction : reg_hit

	assign acc    = psel_i && penable_i;
	assign wr_acc = acc && pwrite_i;
	assign rd_acc = acc && !pwrite_i;
	assign pready_o  = 1'b1;
	assign pslverr_o = 1'b0;
	// Busy spans words in flight, so idle status means RDATA holds them
	assign busy      = (state != ST_IDLE) || (take_pipe != '0);
	assign wait_done = (wait_cnt == '0);
	// One word in flight at most, so a delayed push never meets a full FIFO
	assign room      = fifo_ready && (take_pipe == '0);
	// Commands during a transfer are dropped, not queued
	assign cmd_go   = reg_hit(wr_acc, paddr_i, tbx_pkg::ADDR_CMD) && !busy;
	assign fifo_pop = reg_hit(rd_acc, paddr_i, tbx_pkg::ADDR_RDATA);

	// Pin input from the CPU bus, two stages before use
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cpu_s1 <= '0;
			cpu_s2 <= '0;
		end else begin
			cpu_s1 <= cpu_data_i;
			cpu_s2 <= cpu_s1;
		end
	end

	// Software registers
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			byte_ctrl   <= tbx_pkg::CTRL_RESET;
			wait_cycles <= tbx_pkg::TIMING_RESET;
			wdata       <= '0;
			wdata_full  <= 1'b0;
		end else begin
			if (reg_hit(wr_acc, paddr_i, tbx_pkg::ADDR_CTRL)) begin
				byte_ctrl <= pwdata_i[1:0];
			end
			if (reg_hit(wr_acc, paddr_i, tbx_pkg::ADDR_TIMING)) begin
				wait_cycles <= pwdata_i[3:0];
			end
			if (reg_hit(wr_acc, paddr_i, tbx_pkg::ADDR_WDATA)) begin
				wdata      <= pwdata_i[15:0];
				wdata_full <= 1'b1;
			end else if (state == ST_WRITE && wait_done) begin
				wdata_full <= 1'b0;
			end
		end
	end

	// Loaded in setup, so the access phase needs no wait state
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_o <= tbx_pkg::RDATA_UNMAPPED;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			unique case (paddr_i)
				tbx_pkg::ADDR_CTRL:   prdata_o <= {30'h0, byte_ctrl};
				tbx_pkg::ADDR_TIMING: prdata_o <= {28'h0, wait_cycles};
				tbx_pkg::ADDR_WDATA:  prdata_o <= {16'h0, wdata};
				tbx_pkg::ADDR_RDATA:  prdata_o <= {16'h0, fifo_out};
				tbx_pkg::ADDR_STATUS: prdata_o <= {28'h0, wdata_full,
					!fifo_valid, !fifo_ready, busy};
				default:              prdata_o <= tbx_pkg::RDATA_UNMAPPED;
			endcase
		end
	end

	// Sequencer
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state    <= ST_IDLE;
			cmd_op   <= '0;
			cmd_even <= 1'b0;
			wait_cnt <= '0;
		end else begin
			if (wait_cnt != '0) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
			unique case (state)
				ST_IDLE: begin
					if (cmd_go) begin
						cmd_op   <= pwdata_i[tbx_pkg::CMD_OP_LSB +: 2];
						cmd_even <= pwdata_i[tbx_pkg::CMD_EVEN];
						wait_cnt <= wait_cycles;
						unique case (pwdata_i[tbx_pkg::CMD_OP_LSB +: 2])
							tbx_pkg::CMD_WRITE:  state <= ST_WRITE;
							tbx_pkg::CMD_SINGLE: state <= ST_OPEN;
							tbx_pkg::CMD_PAIR:   state <= ST_OPEN;
							default:             state <= ST_IDLE;
						endcase
					end
				end
				ST_WRITE: begin
					if (wait_done) begin
						state <= ST_IDLE;
					end
				end
				ST_OPEN: begin
					// A full FIFO keeps the drive phase open
					if (wait_done && room) begin
						state <= (cmd_op == tbx_pkg::CMD_PAIR) ? ST_CAPTURE
							: ST_IDLE;
					end
				end
				ST_CAPTURE: state <= ST_EVEN;
				ST_EVEN: begin
					if (room) begin
						state    <= ST_ODD;
						wait_cnt <= wait_cycles;
					end
				end
				ST_ODD: begin
					// Odd word also waits for the even one to land
					if (wait_done && room) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Steering outputs, one flop stage
	always_comb begin
		ctl = '0;
		ctl.even_write_latch_en = 1'b1;
		ctl.odd_write_latch_en  = 1'b1;
		ctl.upper_byte_drive_n  = 1'b1;
		ctl.lower_byte_drive_n  = 1'b1;
		ctl.even_read_latch_en  = 1'b1;
		ctl.odd_read_latch_en   = 1'b1;
		ctl.port_sel = cmd_even;
		unique case (state)
			ST_IDLE: ;
			ST_WRITE, ST_OPEN: begin
				ctl.dir_sel = (state == ST_WRITE);
				ctl.upper_byte_drive_n = !byte_ctrl[tbx_pkg::CTRL_UPPER];
				ctl.lower_byte_drive_n = !byte_ctrl[tbx_pkg::CTRL_LOWER];
			end
			ST_CAPTURE, ST_EVEN, ST_ODD: begin
				// Shared enable falls for both ports together
				ctl.even_read_latch_en = 1'b0;
				ctl.odd_read_latch_en  = 1'b0;
				ctl.port_sel = (state != ST_ODD);
				ctl.upper_byte_drive_n = (state == ST_CAPTURE)
					|| !byte_ctrl[tbx_pkg::CTRL_UPPER];
				ctl.lower_byte_drive_n = (state == ST_CAPTURE)
					|| !byte_ctrl[tbx_pkg::CTRL_LOWER];
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			port_sel_o            <= 1'b1;
			dir_sel_o             <= 1'b0;
			upper_byte_drive_n_o  <= 1'b1;
			lower_byte_drive_n_o  <= 1'b1;
			even_read_latch_en_o  <= 1'b1;
			odd_read_latch_en_o   <= 1'b1;
			even_write_latch_en_o <= 1'b1;
			odd_write_latch_en_o  <= 1'b1;
		end else begin
			port_sel_o            <= ctl.port_sel;
			dir_sel_o             <= ctl.dir_sel;
			upper_byte_drive_n_o  <= ctl.upper_byte_drive_n;
			lower_byte_drive_n_o  <= ctl.lower_byte_drive_n;
			even_read_latch_en_o  <= ctl.even_read_latch_en;
			odd_read_latch_en_o   <= ctl.odd_read_latch_en;
			even_write_latch_en_o <= ctl.even_write_latch_en;
			odd_write_latch_en_o  <= ctl.odd_write_latch_en;
		end
	end

	// CPU-side driver: only during writes, else released
	// Data follows WDATA each cycle; only the enable gates the bus
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			cpu_data_o    <= '0;
			cpu_data_oe_o <= 1'b0;
		end else begin
			cpu_data_o    <= wdata;
			cpu_data_oe_o <= (state == ST_WRITE);
		end
	end

	// Cycle whose bus value becomes a FIFO word
	always_comb begin
		take = 1'b0;
		unique case (state)
			ST_OPEN: take = wait_done && room
				&& cmd_op == tbx_pkg::CMD_SINGLE;
			ST_EVEN: take = room;
			ST_ODD:  take = wait_done && room;
			default: take = 1'b0;
		endcase
	end

	// A word reaches cpu_s2 three edges after its cycle: one for the
	// steering flops, two for the synchroniser; the push waits as long
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			take_pipe <= '0;
		end else begin
			take_pipe <= {take_pipe[1:0], take};
		end
	end

	assign fifo_in   = cpu_s2;
	assign fifo_push = take_pipe[2];

	tbx_fifo #(
		.WIDTH (tbx_pkg::DATA_W),
		.DEPTH (tbx_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.reset_i     (reset_i),
		.in_data_i   (fifo_in),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_ready),
		.out_data_o  (fifo_out),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop)
	);
endmodule : tbx_ctrl

// [dv/tbx_xchg_model.sv]
// Behavioural model of the three-port bus exchanger
`timescale 1ns/100ps
module tbx_xchg_model (
	input  wire tbx_pkg::tbx_ctl_t ctl_i,
	input  wire logic [15:0]       x_i,
	input  wire logic [15:0]       y_i,
	input  wire logic [15:0]       z_i,
	output logic [15:0]            x_o,
	output logic [15:0]            y_o,
	output logic [15:0]            z_o,
	output logic [1:0]             x_oe_o,
	output logic [1:0]             y_oe_o,
	output logic [1:0]             z_oe_o
);
	logic [15:0] y_rd, z_rd;
	logic [1:0]  en;
	wire         wr = ctl_i.dir_sel;
	always_latch if (ctl_i.even_read_latch_en) y_rd <= y_i;
	always_latch if (ctl_i.odd_read_latch_en) z_rd <= z_i;
	// Open write latches let CPU data flow straight through
	always_latch if (ctl_i.even_write_latch_en) y_o <= x_i;
	always_latch if (ctl_i.odd_write_latch_en) z_o <= x_i;
	assign en = ~{ctl_i.upper_byte_drive_n,
		ctl_i.lower_byte_drive_n};
	assign x_oe_o = wr ? 2'h0 : en;
	assign y_oe_o = wr && ctl_i.port_sel ? en : 2'h0;
	assign z_oe_o = wr && !ctl_i.port_sel ? en : 2'h0;
	assign x_o = ctl_i.port_sel ? y_rd : z_rd;
endmodule : tbx_xchg_model

// [dv/tbx_ctrl_sva.sv]
// Assertions on the controller's exchanger steering outputs
`timescale 1ns/100ps
module tbx_ctrl_sva (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic port_sel_o,
	input wire logic dir_sel_o,
	input wire logic upper_byte_drive_n_o,
	input wire logic lower_byte_drive_n_o,
	input wire logic even_read_latch_en_o,
	input wire logic odd_read_latch_en_o,
	input wire logic even_write_latch_en_o,
	input wire logic odd_write_latch_en_o,
	input wire logic cpu_data_oe_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	wire le  = even_read_latch_en_o;
	wire drv = !(upper_byte_drive_n_o && lower_byte_drive_n_o);
	sequence close_s; $fell(le) ##0 !dir_sel_o; endsequence
	sequence hand_s; ##[1:2] port_sel_o ##1 !port_sel_o; endsequence
	wl_open_a: assert property (even_write_latch_en_o && odd_write_latch_en_o)
		else $error("write latch closed");
	rl_shared_a: assert property (le == odd_read_latch_en_o)
		else $error("read latch enables differ");
	pair_order_a: assert property (close_s |-> hand_s)
		else $error("even then odd order broken");
	latch_reopen_a: assert property (close_s |-> ##[1:60] le)
		else $error("read latch left closed");
	hold_read_a: assert property (!le |-> !dir_sel_o && !cpu_data_oe_o)
		else $error("latch closed outside a read");
	bus_dir_a: assert property (cpu_data_oe_o |-> dir_sel_o)
		else $error("CPU bus driven during read");
	write_drive_a: assert property (dir_sel_o && drv |-> cpu_data_oe_o)
		else $error("write without data");
	dir_steady_a: assert property (drv && $past(drv) |-> $stable(dir_sel_o))
		else $error("direction moved while driving");
endmodule : tbx_ctrl_sva
bind tbx_ctrl tbx_ctrl_sva sva (.clock_i, .reset_i, .port_sel_o, .dir_sel_o,
	.upper_byte_drive_n_o, .lower_byte_drive_n_o, .even_read_latch_en_o,
	.odd_read_latch_en_o, .even_write_latch_en_o, .odd_write_latch_en_o,
	.cpu_data_oe_o);

// [dv/test_three_port_bus_exchanger.sv]
// Self-checking bench for the exchanger controller
`timescale 1ns/100ps
module test_three_port_bus_exchanger;
	logic        clock_i, reset_i, psel_i, penable_i, pwrite_i;
	logic        pready_o, pslverr_o, port_sel_o, dir_sel_o, cpu_data_oe_o;
	logic        upper_byte_drive_n_o, lower_byte_drive_n_o;
	logic        even_read_latch_en_o, odd_read_latch_en_o;
	logic        even_write_latch_en_o, odd_write_latch_en_o;
	logic [7:0]  paddr_i, cyc;
	logic [31:0] pwdata_i, prdata_o, q, seed;
	logic [15:0] cpu_data_o, x_m, y_o, z_o, ym, zm, ys, zs, w, ev, od;
	logic [1:0]  x_oe, y_oe, z_oe;
	int          mismatches, checks_done, i, n;
	wire tbx_pkg::tbx_ctl_t ctl = {port_sel_o, dir_sel_o,
		upper_byte_drive_n_o, lower_byte_drive_n_o, even_read_latch_en_o,
		odd_read_latch_en_o, even_write_latch_en_o, odd_write_latch_en_o};
	// Bytes nobody drives float: a changing pattern, not the last value
	wire [15:0]  cpu_data_i = {cpu_data_oe_o ? cpu_data_o[15:8] :
		x_oe[1] ? x_m[15:8] : cyc, cpu_data_oe_o ? cpu_data_o[7:0] :
		x_oe[0] ? x_m[7:0] : ~cyc};
	tbx_ctrl dut (.clock_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .port_sel_o, .dir_sel_o,
		.upper_byte_drive_n_o, .lower_byte_drive_n_o, .even_read_latch_en_o,
		.odd_read_latch_en_o, .even_write_latch_en_o, .odd_write_latch_en_o,
		.cpu_data_i, .cpu_data_o, .cpu_data_oe_o);
	tbx_xchg_model xchg (.ctl_i(ctl), .x_i(cpu_data_i), .y_i(ym), .z_i(zm),
		.x_o(x_m), .y_o, .z_o, .x_oe_o(x_oe), .y_oe_o(y_oe), .z_oe_o(z_oe));
	initial begin
		clock_i = 1'h0;
		forever #25 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 8'h1;
		if (y_oe == 2'h3) ys <= y_o;
		if (z_oe == 2'h3) zs <= z_o;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] exp_rd(input logic e);
		return {16'h0, e ? ym : zm};
	endfunction : exp_rd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d = 32'h0);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, wr, a, d};
		@(posedge clock_i);
		penable_i <= 1'h1;
		do @(posedge clock_i); while (pready_o !== 1'h1);
		q = prdata_o;
		chk({31'h0, pslverr_o}, 32'h0);
		{psel_i, penable_i} <= 2'h0;
		@(posedge clock_i);
	endtask : apb
	task automatic cmd(input logic [1:0] op, input logic e);
		apb(1'h1, tbx_pkg::ADDR_CMD, {29'h0, e, op});
	endtask : cmd
	task automatic idle();
		for (int k = 0; k < 200; k++) begin
			apb(1'h0, tbx_pkg::ADDR_STATUS);
			if (q[tbx_pkg::STAT_BUSY] === 1'h0) return;
		end
		chk(q, 32'h0);
	endtask : idle
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	initial begin
		reset_i = 1'h1;
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 43'h0;
		{ym, zm, ys, zs, ev, od, cyc} = 104'h0;
		seed = 32'hebb4;
		repeat (5) @(posedge clock_i);
		reset_i <= 1'h0;
		@(negedge clock_i);
		chk({23'h0, ctl, cpu_data_oe_o}, 32'h17e);
		@(posedge clock_i);
		apb(1'h0, tbx_pkg::ADDR_CTRL);
		chk(q, 32'(tbx_pkg::CTRL_RESET));
		apb(1'h0, tbx_pkg::ADDR_TIMING);
		chk(q, 32'(tbx_pkg::TIMING_RESET));
		w = 16'(rnd());
		apb(1'h1, tbx_pkg::ADDR_TIMING, {28'h0, w[3:0]});
		apb(1'h0, tbx_pkg::ADDR_TIMING);
		chk(q, {28'h0, w[3:0]});
		apb(1'h1, 8'h1c, 32'hffff_ffff);
		apb(1'h0, 8'h1c);
		chk(q, tbx_pkg::RDATA_UNMAPPED);
		for (i = 0; i < 4; i++) begin
			w = 16'(rnd());
			apb(1'h1, tbx_pkg::ADDR_WDATA, {16'h0, w});
			cmd(tbx_pkg::CMD_WRITE, i[0]);
			idle();
			if (i[0]) ev = w;
			else od = w;
			chk({ys, zs}, {ev, od});
		end
		for (i = 0; i < 4; i++) begin
			{ym, zm} <= rnd();
			cmd(tbx_pkg::CMD_SINGLE, i[0]);
			idle();
			apb(1'h0, tbx_pkg::ADDR_RDATA);
			chk(q, exp_rd(i[0]));
		end
		{ev, od} = rnd();
		{ym, zm} <= {ev, od};
		cmd(tbx_pkg::CMD_PAIR, 1'h1);
		for (n = 0; n < 60 && even_read_latch_en_o !== 1'h0; n++)
			@(negedge clock_i);
		chk({31'h0, even_read_latch_en_o}, 32'h0);
		@(posedge clock_i);
		// Memories move once captured; the latched words must not
		{ym, zm} <= ~{ev, od};
		idle();
		apb(1'h0, tbx_pkg::ADDR_RDATA);
		chk(q, {16'h0, ev});
		apb(1'h0, tbx_pkg::ADDR_RDATA);
		chk(q, {16'h0, od});
		for (i = 0; i < 17; i++) begin
			cmd(tbx_pkg::CMD_SINGLE, 1'h1);
			if (i < 16) idle();
		end
		apb(1'h0, tbx_pkg::ADDR_STATUS);
		chk({29'h0, q[2:0]}, 32'h3);
		for (i = 0; i < 17; i++) begin
			apb(1'h0, tbx_pkg::ADDR_RDATA);
			chk(q, exp_rd(1'h1));
			idle();
		end
		apb(1'h0, tbx_pkg::ADDR_STATUS);
		chk({29'h0, q[2:0]}, 32'h4);
		print_verdict();
	end
	initial begin
		repeat (30000) @(posedge clock_i);
		mismatches++;
		print_verdict();
	end
endmodule : test_three_port_bus_exchanger
